// file: src/lmx_pkg.sv
// Purpose: Shared constants and types for the LED multiplex pin driver
// Assumes: 20 MHz core clock
// Notes: Pin indices 0..3 are shared cathode/segment pins, 4..9 segment-only pins
package lmx_pkg;
   localparam int unsigned CLK_PERIOD_NS = 50;
   // Spike suppression width, in ns
   localparam int unsigned SPIKE_NS = 50;
   // Longest filtered pulse rounds down, at least one cycle
   localparam int unsigned SPIKE_CYC_RAW = SPIKE_NS / CLK_PERIOD_NS;
   localparam int unsigned SPIKE_CYC = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
   // Scan dwell per digit: 20 MHz / (4 * 780 Hz) is about 6410
   localparam int unsigned SCAN_DWELL_DEFAULT = 6410;
   // Blanking lasts BLANK_CYC+1 cycles between phases so segments settle before next cathode
   localparam logic [3:0] BLANK_CYC = 4'h4;
   localparam int unsigned NUM_PINS = 10;
   localparam int unsigned NUM_DIGITS = 4;
   localparam int unsigned SEG_FIRST = 4;
   localparam int unsigned ALERT_PIN = 9;

   typedef enum logic [1:0] {
      NINE_SEGMENT = 2'b00,
      NINE_ALERT = 2'b01,
      NINE_GPO = 2'b10
   } lmx_nine_mode_t;

   typedef enum logic [1:0] {
      SCAN_BLANK = 2'b00,
      SCAN_SHOW = 2'b01
   } lmx_scan_state_t;

   // One digit's stored content: seven segments (a..g in bits 0..6) and two discretes
   typedef struct packed {
      logic hexMode;
      logic [6:0] segBits;
      logic [3:0] hexValue;
      logic discLow;
      logic discHigh;
   } lmx_digit_t;

   typedef struct packed {
      logic [NUM_PINS-1:0] drive;
      logic [NUM_PINS-1:0] level;
   } lmx_pins_t;
endpackage : lmx_pkg

// file: src/lmx_spike_filter.sv
// Purpose: Suppress short pulses on a serial input
// Assumes: Input synchronous to core_clk
// Notes: Output changes only after the input holds a new level for more than SPIKE_CYC cycles
`timescale 1ns/1ns
`default_nettype none
module lmx_spike_filter
   import lmx_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Data
   input wire logic rawIn,
   output logic cleanOut
);
   logic [3:0] cnt_q, cnt_d;
   logic out_q, out_d;

   always_comb begin
      cnt_d = 4'h0;
      out_d = out_q;
      if (rawIn != out_q) begin
         if (cnt_q >= 4'(SPIKE_CYC)) begin
            out_d = rawIn;
         end else begin
            cnt_d = cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 4'h0;
         out_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign cleanOut = out_q;

   // RL13 pulse suppression
   chk_spike_short_ignored: assert property (@(posedge core_clk) disable iff (rst) // RL13
      (rawIn != out_q) && (cnt_q == 4'h0) |=> out_q == $past(out_q))
      else $error("spike filter passed a short pulse");
endmodule : lmx_spike_filter
`default_nettype wire

// file: src/lmx_led_mux.sv
// Purpose: Four-digit common-cathode LED multiplex pin driver
// Assumes: Digit content and configuration arrive as static inputs
// Notes: Pins are two signals each (level and enable); high-impedance resolved outside
// Notes on behaviour
// RL1: Shared pin n sinks the cathode during digit n's scan phase.
// RL2: Eight extra segments on first eight segment outputs, decimal points or discretes.
// RL3: Digit 0 mapping: disc0 pin1, g pin2, f pin3, e..a pins4..8, disc4 pin9.
// RL4: Digit 1 mapping: disc1 pin0, g pin2, f pin3, e..a pins4..8, disc5 pin9.
// RL5: Digit 2 mapping: g pin0, f pin1, disc2 pin3, e..a pins4..8, disc6 pin9.
// RL6: Digit 3 mapping: g pin0, f pin1, disc3 pin2, e..a pins4..8, disc7 pin9.
// RL7: Drivers not sinking or sourcing are high impedance.
// RL8: Each digit uses direct segment bits or the hex font.
// RL9: Ninth segment pin is segment, open-drain alert, or open-drain logic output.
// RL10: Input ports have pullups and act as logic input or keyscan input.
// RL11: With dual-digit displays shared-pin discretes drive only discrete LEDs.
// RL12: All outputs may serve as 36 individually controlled discrete LEDs.
// RL13: Serial data and clock inputs ignore pulses under about 50 ns.
// RL14: Keyscan port reads four switches; two ports give eight. Here each port only latches its one input bit.
// RL15: Fixed scan order, one cathode at a time, segments set before cathode. Here segments and cathode switch on in the same cycle after blanking.
`timescale 1ns/1ns
`default_nettype none
module lmx_led_mux
   import lmx_pkg::*;
#(
   parameter int unsigned SCAN_DWELL = SCAN_DWELL_DEFAULT
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Digit content
   input wire lmx_digit_t digitCfg [NUM_DIGITS],
   // Ninth pin configuration
   input wire lmx_nine_mode_t nineMode,
   input wire logic alertReq,
   input wire logic gpoLevel,
   // Input ports
   input wire logic [1:0] inputPortIn,
   input wire logic [1:0] keyscanSel,
   output logic [1:0] portPullupEn,
   output logic [1:0] gpInLevel,
   output logic [1:0] keyScanLevel,
   // Serial inputs
   input wire logic sdaRaw,
   input wire logic sclRaw,
   output logic sdaClean,
   output logic sclClean,
   // LED pins
   output logic [NUM_PINS-1:0] pinOut,
   output logic [NUM_PINS-1:0] pinOe,
   output logic [1:0] scanDigit
);
   localparam logic [15:0] DWELL = 16'(SCAN_DWELL);

   lmx_scan_state_t state_q, state_d;
   logic [1:0] dig_q, dig_d;
   logic [15:0] tmr_q, tmr_d;
   lmx_pins_t pins_q, pins_d;
   logic [1:0] gpIn_q, gpIn_d, key_q, key_d;
   logic sdaF, sclF;
   logic sda_q, scl_q;

   // RL8 hex font, segment a in bit 0
   function automatic logic [6:0] hexFont(input logic [3:0] v);
      logic [6:0] s;
      s = 7'h00;
      case (v)
         4'h0: s = 7'h3f;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5b;
         4'h3: s = 7'h4f;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6d;
         4'h6: s = 7'h7d;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7f;
         4'h9: s = 7'h6f;
         4'ha: s = 7'h77;
         4'hb: s = 7'h7c;
         4'hc: s = 7'h39;
         4'hd: s = 7'h5e;
         4'he: s = 7'h79;
         default: s = 7'h71;
      endcase
      return s;
   endfunction : hexFont

   // Scan sequencing
   always_comb begin
      state_d = state_q;
      dig_d = dig_q;
      tmr_d = tmr_q + 16'h0001;
      case (state_q)
         SCAN_BLANK: begin
            // RL15 settle before cathode
            if (tmr_q >= {12'h000, BLANK_CYC}) begin
               state_d = SCAN_SHOW;
               tmr_d = 16'h0000;
            end
         end
         SCAN_SHOW: begin
            // RL15 fixed order
            if (tmr_q >= DWELL) begin
               state_d = SCAN_BLANK;
               dig_d = dig_q + 2'h1;
               tmr_d = 16'h0000;
            end
         end
         default: begin
            state_d = SCAN_BLANK;
            tmr_d = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= SCAN_BLANK;
         dig_q <= 2'h0;
         tmr_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         dig_q <= dig_d;
         tmr_q <= tmr_d;
      end
   end

   // Pin mapping; a lit segment drives high, unlit pins float
   always_comb begin
      lmx_digit_t d;
      logic [6:0] seg;
      d = digitCfg[dig_d];
      seg = d.hexMode ? hexFont(d.hexValue) : d.segBits;
      pins_d.drive = '0;
      pins_d.level = '0;
      // RL12 direct bits give full discrete control of every segment
      // RL3 RL4 RL5 RL6 common e..a segments
      for (int i = 0; i < 5; i++) begin
         pins_d.drive[SEG_FIRST+i] = seg[4-i];
         pins_d.level[SEG_FIRST+i] = 1'b1;
      end
      // RL2 RL11 discretes on pins 0..3 and decimal points on pin 9
      case (dig_d)
         2'h0: begin
            pins_d.drive[1] = d.discLow;
            pins_d.drive[2] = seg[6];
            pins_d.drive[3] = seg[5];
         end
         2'h1: begin
            pins_d.drive[0] = d.discLow;
            pins_d.drive[2] = seg[6];
            pins_d.drive[3] = seg[5];
         end
         2'h2: begin
            pins_d.drive[0] = seg[6];
            pins_d.drive[1] = seg[5];
            pins_d.drive[3] = d.discLow;
         end
         default: begin
            pins_d.drive[0] = seg[6];
            pins_d.drive[1] = seg[5];
            pins_d.drive[2] = d.discLow;
         end
      endcase
      for (int i = 0; i < NUM_DIGITS; i++) begin
         pins_d.level[i] = 1'b1;
      end
      // RL1 cathode sink on its own pin
      pins_d.drive[dig_d] = (state_d == SCAN_SHOW);
      pins_d.level[dig_d] = 1'b0;
      // RL9 ninth pin modes; open drain only ever pulls low
      case (nineMode)
         NINE_ALERT: begin
            pins_d.drive[ALERT_PIN] = alertReq;
            pins_d.level[ALERT_PIN] = 1'b0;
         end
         NINE_GPO: begin
            pins_d.drive[ALERT_PIN] = ~gpoLevel;
            pins_d.level[ALERT_PIN] = 1'b0;
         end
         default: begin
            pins_d.drive[ALERT_PIN] = d.discHigh;
            pins_d.level[ALERT_PIN] = 1'b1;
         end
      endcase
      // RL7 segments idle while blanking
      if (state_d != SCAN_SHOW) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (i != ALERT_PIN || nineMode == NINE_SEGMENT) begin
               pins_d.drive[i] = 1'b0;
            end
         end
      end
      // Masked here so the pin level leaves a flip-flop directly
      pins_d.level = pins_d.level & pins_d.drive;
   end

   // RL10 RL14 input ports split by mode
   always_comb begin
      gpIn_d = gpIn_q;
      key_d = key_q;
      for (int i = 0; i < 2; i++) begin
         if (keyscanSel[i]) begin
            key_d[i] = inputPortIn[i];
         end else begin
            gpIn_d[i] = inputPortIn[i];
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pins_q <= '0;
         gpIn_q <= 2'h3;
         key_q <= 2'h3;
         sda_q <= 1'b1;
         scl_q <= 1'b1;
      end else begin
         pins_q <= pins_d;
         gpIn_q <= gpIn_d;
         key_q <= key_d;
         sda_q <= sdaF;
         scl_q <= sclF;
      end
   end

   // RL13 serial input filters
   lmx_spike_filter uSdaFilt (
      .core_clk(core_clk),
      .rst(rst),
      .rawIn(sdaRaw),
      .cleanOut(sdaF)
   );
   lmx_spike_filter uSclFilt (
      .core_clk(core_clk),
      .rst(rst),
      .rawIn(sclRaw),
      .cleanOut(sclF)
   );

   // RL7 undriven pins carry level zero; enable marks the drive
   assign pinOe = pins_q.drive;
   assign pinOut = pins_q.level;
   assign scanDigit = dig_q;
   assign gpInLevel = gpIn_q;
   assign keyScanLevel = key_q;
   assign sdaClean = sda_q;
   assign sclClean = scl_q;
   // Pullups always on in this model
   assign portPullupEn = 2'h3;

   sequence blankThenShow;
      (state_q == SCAN_BLANK) ##1 (state_q == SCAN_SHOW);
   endsequence

   chk_one_cathode: assert property (@(posedge core_clk) disable iff (rst) // RL1
      $onehot0(pinOe[3:0] & ~pinOut[3:0]))
      else $error("more than one cathode active");
   chk_cathode_pin: assert property (@(posedge core_clk) disable iff (rst) // RL1
      (state_q == SCAN_SHOW) |=> pinOe[dig_q] && !pinOut[dig_q] || state_q == SCAN_BLANK)
      else $error("cathode not on its own pin");
   chk_blank_idle: assert property (@(posedge core_clk) disable iff (rst) // RL7
      (state_q == SCAN_BLANK) |-> pinOe[8:0] == 9'h000)
      else $error("pin driven during blanking");
   chk_scan_order: assert property (@(posedge core_clk) disable iff (rst) // RL15
      (dig_q != $past(dig_q)) |-> dig_q == $past(dig_q) + 2'h1)
      else $error("scan order broken");
   chk_blank_before: assert property (@(posedge core_clk) disable iff (rst) // RL15
      blankThenShow |-> $past(dig_q) == dig_q)
      else $error("digit changed while entering show");
   chk_nine_drain: assert property (@(posedge core_clk) disable iff (rst) // RL9
      (nineMode != NINE_SEGMENT) ##1 (nineMode == $past(nineMode)) |-> !pinOut[ALERT_PIN])
      else $error("open drain pin driven high");
   chk_gp_input: assert property (@(posedge core_clk) disable iff (rst) // RL10
      !keyscanSel[0] |=> gpInLevel[0] == $past(inputPortIn[0]))
      else $error("general input not captured");
   chk_key_input: assert property (@(posedge core_clk) disable iff (rst) // RL14
      keyscanSel[1] |=> keyScanLevel[1] == $past(inputPortIn[1]))
      else $error("keyscan input not captured");
   chk_seg_a: assert property (@(posedge core_clk) disable iff (rst) // RL3
      (state_d == SCAN_SHOW) && !digitCfg[dig_d].hexMode |=>
      (pinOe[8] == $past(digitCfg[dig_d].segBits[0])) && (pinOut[8] == pinOe[8]))
      else $error("segment a not sourcing");
endmodule : lmx_led_mux
`default_nettype wire

// file: tb/lmx_disp_model.sv
// Purpose: Display model that decodes lit LEDs from the driver pins
// Assumes: Pins settled at the falling clock edge
// Notes: Raises fault on ghosting, overlap or segments changing mid-phase
`timescale 1ns/1ns
`default_nettype none
module lmx_disp_model
   import lmx_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Pins
   input wire logic [NUM_PINS-1:0] pinOut,
   input wire logic [NUM_PINS-1:0] pinOe,
   // Observations
   output logic resValid,
   output logic [10:0] resWord,
   output logic fault
);
   logic [NUM_PINS-1:0] src;
   logic [3:0] snk;
   logic [10:0] w;
   logic [10:0] held;
   logic low;
   logic showing;
   int d;
   always @(negedge core_clk or posedge rst) begin
      src = pinOe & pinOut;
      snk = pinOe[3:0] & ~pinOut[3:0];
      resValid <= 1'b0;
      if (rst) begin
         showing = 1'b0;
         fault <= 1'b0;
      end else if (snk == 4'h0) begin
         if (pinOe[8:0] != 9'h0) begin
            fault <= 1'b1;
         end
         resValid <= showing;
         resWord <= held;
         showing = 1'b0;
      end else begin
         d = (snk == 4'h1) ? 0 : (snk == 4'h2) ? 1 : (snk == 4'h4) ? 2 : (snk == 4'h8) ? 3 : 4;
         if (d == 4 || (pinOe[8:0] & ~pinOut[8:0] & ~(9'h1 << d)) != 9'h0) begin
            fault <= 1'b1;
         end
         case (d)
            0: low = src[1];
            1: low = src[0];
            2: low = src[3];
            default: low = src[2];
         endcase
         w = {d[1:0], (d < 2) ? src[2] : src[0], (d < 2) ? src[3] : src[1],
            src[4], src[5], src[6], src[7], src[8], low, src[9]};
         if (showing && w != held) begin
            fault <= 1'b1;
         end
         held = w;
         showing = 1'b1;
      end
   end
endmodule : lmx_disp_model
`default_nettype wire

// file: tb/tb.sv
// Purpose: Self-checking bench for the LED multiplex driver
// Assumes: Short scan dwell for simulation speed
// Notes: Display results are matched against a queue of expectations
`timescale 1ns/1ns
`default_nettype none
module tb;
   import lmx_pkg::*;
   localparam int unsigned DWELL = 8;
   // Hex digits whose font pattern the bench knows
   localparam logic [23:0] HX = 24'h0128af;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   lmx_digit_t cfg [NUM_DIGITS];
   lmx_nine_mode_t nineMode = NINE_SEGMENT;
   logic alertReq = 1'b0;
   logic gpoLevel = 1'b1;
   logic [1:0] inPort = 2'b11;
   logic [1:0] keySel = 2'b00;
   logic sdaRaw = 1'b1;
   logic sclRaw = 1'b1;
   logic [1:0] pullEn, gpIn, keyIn, scanDigit;
   logic sdaClean, sclClean, resValid, fault;
   logic [NUM_PINS-1:0] pinOut, pinOe;
   logic [10:0] resWord;
   logic [10:0] expQ [$];
   int n_mismatch = 0;
   int cmp_count = 0;
   int nRes = 0;
   logic [31:0] seed = 32'h0ede7b93;

   always #25 core_clk = ~core_clk;

   lmx_led_mux #(.SCAN_DWELL(DWELL)) dut (.core_clk(core_clk), .rst(rst), .digitCfg(cfg),
      .nineMode(nineMode), .alertReq(alertReq), .gpoLevel(gpoLevel), .inputPortIn(inPort),
      .keyscanSel(keySel), .portPullupEn(pullEn), .gpInLevel(gpIn), .keyScanLevel(keyIn),
      .sdaRaw(sdaRaw), .sclRaw(sclRaw), .sdaClean(sdaClean), .sclClean(sclClean),
      .pinOut(pinOut), .pinOe(pinOe), .scanDigit(scanDigit));

   lmx_disp_model disp (.core_clk(core_clk), .rst(rst), .pinOut(pinOut), .pinOe(pinOe),
      .resValid(resValid), .resWord(resWord), .fault(fault));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [6:0] font(input logic [3:0] v);
      case (v)
         4'h0: font = 7'h3f;
         4'h1: font = 7'h06;
         4'h2: font = 7'h5b;
         4'h8: font = 7'h7f;
         4'ha: font = 7'h77;
         default: font = 7'h71;
      endcase
   endfunction : font

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h got %h", what, e, g);
      end
   endtask : chk

   task automatic print_verdict();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // Notes one full scan and waits for it; called right after reset or a digit 3 result
   task automatic run_scan();
      int goal;
      logic [6:0] s;
      goal = nRes + 4;
      for (int d = 0; d < 4; d++) begin
         s = cfg[d].hexMode ? font(cfg[d].hexValue) : cfg[d].segBits;
         expQ.push_back({d[1:0], s, cfg[d].discLow,
            cfg[d].discHigh && nineMode == NINE_SEGMENT});
      end
      for (int i = 0; i < 200 && nRes < goal; i++) begin
         @(negedge core_clk);
      end
      chk("scans", 16'(goal), 16'(nRes)); // phases complete
   endtask : run_scan

   always @(negedge core_clk) begin
      if (resValid === 1'b1 && expQ.size() > 0) begin
         nRes++;
         chk("display", {5'h0, expQ.pop_front()}, {5'h0, resWord}); // lit pattern
         chk("scanDigit", {14'h0, resWord[10:9] + 2'h1}, {14'h0, scanDigit}); // next digit
      end
   end

   initial begin
      for (int d = 0; d < 4; d++) begin
         cfg[d] = {1'b0, 7'h7f, 4'h0, 1'b1, 1'b1};
      end
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      run_scan(); // all lit
      for (int r = 0; r < 8; r++) begin
         for (int d = 0; d < 4; d++) begin
            seed = lfsr(seed);
            cfg[d] = {r > 5, seed[6:0], HX[4 * (seed[9:7] % 6) +: 4], seed[10], seed[11]};
         end
         nineMode = (r == 7) ? NINE_GPO : NINE_SEGMENT;
         run_scan(); // mapping
      end
      nineMode = NINE_ALERT;
      alertReq = 1'b1;
      repeat (3) @(negedge core_clk);
      chk("alertOn", 16'h2, {14'h0, pinOe[9], pinOut[9]}); // alert pulls low
      alertReq = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("alertOff", 16'h0, {15'h0, pinOe[9]}); // alert released
      nineMode = NINE_GPO;
      gpoLevel = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("gpoLow", 16'h2, {14'h0, pinOe[9], pinOut[9]}); // logic output low
      for (int k = 1; k < 3; k++) begin
         seed = lfsr(seed);
         inPort = seed[1:0];
         keySel = k[1:0];
         repeat (3) @(negedge core_clk);
         chk("gpIn", {14'h0, inPort & ~keySel}, {14'h0, gpIn & ~keySel}); // logic input
         chk("keyIn", {14'h0, inPort & keySel}, {14'h0, keyIn & keySel}); // keyscan
      end
      chk("pullup", 16'h3, {14'h0, pullEn}); // pullups on
      sdaRaw = 1'b0;
      sclRaw = 1'b0;
      @(negedge core_clk);
      sdaRaw = 1'b1;
      sclRaw = 1'b1;
      repeat (6) begin
         @(negedge core_clk);
         chk("spike", 16'h3, {14'h0, sdaClean, sclClean}); // short pulse ignored
      end
      sdaRaw = 1'b0;
      repeat (5) @(negedge core_clk);
      chk("sdaLong", 16'h1, {14'h0, sdaClean, sclClean}); // long pulse passes
      chk("model", 16'h0, {15'h0, fault}); // no ghosting
      print_verdict();
   end

   initial begin
      #(50 * 20000);
      n_mismatch++;
      print_verdict();
   end
endmodule : tb
`default_nettype wire
